/* nibdir_pkg.sv */
// constants and types shared by the nibble-exchange / direction-load decoder
package nibdir_pkg;

    // ************************************************************
    // instruction encodings
    // ************************************************************
    localparam int         INSTR_W        = 14;
    localparam logic [5:0] NIBX_OPCODE    = 6'h0e;     // 00 1110 d fffffff
    localparam int         NIBX_OP_MSB    = 13;
    localparam int         NIBX_OP_LSB    = 8;
    localparam int         NIBX_DEST_BIT  = 7;
    localparam int         FILE_ADDR_W    = 7;
    localparam logic [9:0] DIRLD_OPCODE   = 10'h006;   // 00 0000 0110 0fff
    localparam int         DIRLD_OP_MSB   = 13;
    localparam int         DIRLD_OP_LSB   = 4;
    localparam int         DIRLD_ZERO_BIT = 3;
    localparam logic [2:0] DIR_SEL_FIRST  = 3'h5;
    localparam logic [2:0] DIR_SEL_LAST   = 3'h7;

    // ************************************************************
    // destination select
    // ************************************************************
    localparam logic DEST_ACCUM = 1'b0;
    localparam logic DEST_FILE  = 1'b1;

    // ************************************************************
    // direction register bank
    // ************************************************************
    localparam int         DIR_COUNT      = 3;
    localparam int         DIR_IDX_W      = 2;
    localparam logic [7:0] DIR_FILE_BASE  = 8'h85;     // ordinary file addresses 0x85..0x87
    localparam logic [7:0] DIR_RESET      = 8'hff;     // all pins input after reset
    localparam logic [7:0] FILE_RDATA_NONE = 8'h00;

    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_NIBX,
        OP_DIRLD,
        OP_DIRLD_BAD
    } op_e;

endpackage : nibdir_pkg

/* dir_bank_if.sv */
// carrier between the decoder and the direction register bank
interface dir_bank_if;
    import nibdir_pkg::*;

    logic                  ld_we;     // direction-load write strobe
    logic [DIR_IDX_W-1:0]  ld_idx;
    byte_t                 ld_data;
    logic                  fa_valid;  // ordinary file access
    logic                  fa_we;
    logic [7:0]            fa_addr;
    byte_t                 fa_wdata;
    byte_t                 fa_rdata;
    logic                  fa_rvalid;
    logic                  fa_hit;
    byte_t                 dir_q [DIR_COUNT];

    modport ctrl (
        output ld_we, ld_idx, ld_data, fa_valid, fa_we, fa_addr, fa_wdata,
        input  fa_rdata, fa_rvalid, fa_hit, dir_q
    );
    modport bank (
        input  ld_we, ld_idx, ld_data, fa_valid, fa_we, fa_addr, fa_wdata,
        output fa_rdata, fa_rvalid, fa_hit, dir_q
    );
endinterface : dir_bank_if

/* dir_bank.sv */
// three port direction registers with two write paths and a registered read port
module dir_bank
    import nibdir_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rstn,
    dir_bank_if.bank   bus
);

    typedef struct packed {
        byte_t [DIR_COUNT-1:0] dir;
        byte_t                 rdata;
        logic                  rvalid;
        logic                  hit;
    } bank_s;

    bank_s st;
    bank_s next_st;

    function automatic logic addr_in_bank(input logic [7:0] a);
        return (a >= DIR_FILE_BASE) && (a < DIR_FILE_BASE + 8'(DIR_COUNT));
    endfunction : addr_in_bank

    always_comb begin
        logic [7:0]           off;
        logic [DIR_IDX_W-1:0] fidx;
        off     = '0;
        fidx    = '0;
        next_st = st;
        off     = bus.fa_addr - DIR_FILE_BASE;
        fidx    = off[DIR_IDX_W-1:0];
        // ordinary file write first so a same-cycle direction load overrides it
        if (bus.fa_valid && bus.fa_we && addr_in_bank(bus.fa_addr)) begin
            next_st.dir[fidx] = bus.fa_wdata; // RL4
        end
        if (bus.ld_we) begin
            next_st.dir[bus.ld_idx] = bus.ld_data; // RL3
        end
        next_st.rvalid = bus.fa_valid && !bus.fa_we;
        next_st.hit    = bus.fa_valid && addr_in_bank(bus.fa_addr);
        // read returns the value as it stands after this edge
        if (bus.fa_valid && !bus.fa_we && addr_in_bank(bus.fa_addr)) begin
            next_st.rdata = next_st.dir[fidx]; // RL4
        end else begin
            next_st.rdata = FILE_RDATA_NONE;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st.dir    <= {DIR_COUNT{DIR_RESET}};
            st.rdata  <= FILE_RDATA_NONE;
            st.rvalid <= 1'b0;
            st.hit    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.fa_rdata  = st.rdata;
    assign bus.fa_rvalid = st.rvalid;
    assign bus.fa_hit    = st.hit;
    for (genvar i = 0; i < DIR_COUNT; i++) begin : g_dir
        assign bus.dir_q[i] = st.dir[i];
    end

endmodule : dir_bank

/* nibdir_core.sv */
// decode and execute of the nibble-exchange and direction-load instructions
// How it works
// (RL1) 00 1110 d fffffff: result swaps high and low nibbles of the file register.
// (RL2) d=0 writes result to accumulator only; d=1 writes it back to the file.
// (RL3) 00 0000 0110 0fff copies accumulator to direction register fff, valid 5..7.
// (RL4) direction registers also read and written by ordinary file addressing.
// (RL5) one word, one cycle each; carry, digit-carry and zero flags never touched.
module nibdir_core
    import nibdir_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               instr_valid,
    input  wire logic [INSTR_W-1:0] instr,
    input  wire byte_t              w_value,
    input  wire byte_t              file_value,
    input  wire logic               fa_valid,
    input  wire logic               fa_we,
    input  wire logic [7:0]         fa_addr,
    input  wire byte_t              fa_wdata,
    output logic [FILE_ADDR_W-1:0]  file_addr,
    output logic                    w_we,
    output byte_t                   w_wdata,
    output logic                    f_we,
    output logic [FILE_ADDR_W-1:0]  f_waddr,
    output byte_t                   f_wdata,
    output logic                    flags_we,
    output logic                    exec_done,
    output logic                    bad_dir_sel,
    output byte_t                   fa_rdata,
    output logic                    fa_rvalid,
    output logic                    fa_hit,
    output byte_t                   dir_a,
    output byte_t                   dir_b,
    output byte_t                   dir_c
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic                   w_we;
        byte_t                  w_wdata;
        logic                   f_we;
        logic [FILE_ADDR_W-1:0] f_waddr;
        byte_t                  f_wdata;
        logic                   done;
        logic                   bad_sel;
        logic [FILE_ADDR_W-1:0] file_addr;
        logic                   flags_we;
    } core_s;

    core_s st;
    core_s next_st;

    dir_bank_if bank_bus ();

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic is_nibx(input logic [INSTR_W-1:0] iw);
        return iw[NIBX_OP_MSB:NIBX_OP_LSB] == NIBX_OPCODE;
    endfunction : is_nibx

    // bit 3 must be clear, otherwise the word belongs to another instruction
    function automatic logic is_dirld(input logic [INSTR_W-1:0] iw);
        return (iw[DIRLD_OP_MSB:DIRLD_OP_LSB] == DIRLD_OPCODE) && !iw[DIRLD_ZERO_BIT];
    endfunction : is_dirld

    function automatic logic dir_sel_ok(input logic [2:0] sel);
        return (sel >= DIR_SEL_FIRST) && (sel <= DIR_SEL_LAST);
    endfunction : dir_sel_ok

    function automatic op_e decode(input logic [INSTR_W-1:0] iw);
        op_e op;
        op = OP_NONE;
        if (is_nibx(iw)) begin
            op = OP_NIBX; // RL1
        end else if (is_dirld(iw)) begin
            if (dir_sel_ok(iw[2:0])) begin
                op = OP_DIRLD; // RL3
            end else begin
                op = OP_DIRLD_BAD;
            end
        end
        return op;
    endfunction : decode

    // selector 5..7 maps onto bank slots 0..2
    function automatic logic [DIR_IDX_W-1:0] dir_index(input logic [2:0] sel);
        logic [2:0] off;
        off = sel - DIR_SEL_FIRST;
        return off[DIR_IDX_W-1:0];
    endfunction : dir_index

    function automatic byte_t swap_nibbles(input byte_t v);
        return {v[3:0], v[7:4]};
    endfunction : swap_nibbles

    // ************************************************************
    // instruction fields
    // ************************************************************
    op_e                    op_now;
    logic                   dest_bit;
    logic [FILE_ADDR_W-1:0] field_addr;
    logic [2:0]             dir_sel;
    byte_t                  swapped;

    assign op_now     = instr_valid ? decode(instr) : OP_NONE;
    assign dest_bit   = instr[NIBX_DEST_BIT];
    assign field_addr = instr[FILE_ADDR_W-1:0];
    assign dir_sel    = instr[2:0];
    // file_value already belongs to field_addr, so the swap costs no extra cycle
    assign swapped    = swap_nibbles(file_value); // RL1

    // ************************************************************
    // direction-load path
    // ************************************************************
    // a bad selector never raises the strobe, so no stray slot is written
    assign bank_bus.ld_we   = (op_now == OP_DIRLD); // RL3
    assign bank_bus.ld_idx  = dir_index(dir_sel);
    assign bank_bus.ld_data = w_value; // RL3

    // ************************************************************
    // execute
    // ************************************************************
    always_comb begin
        next_st           = st;
        next_st.w_we      = 1'b0;
        next_st.f_we      = 1'b0;
        next_st.flags_we  = 1'b0; // RL5
        next_st.done      = 1'b0;
        next_st.bad_sel   = 1'b0;
        // the address echo follows every word, valid or not
        next_st.file_addr = field_addr;
        unique case (op_now)
            OP_NIBX: begin
                next_st.done = 1'b1; // RL5
                if (dest_bit == DEST_FILE) begin
                    next_st.f_we    = 1'b1; // RL2
                    next_st.f_waddr = field_addr;
                    next_st.f_wdata = swapped; // RL1
                end else begin
                    next_st.w_we    = 1'b1; // RL2
                    next_st.w_wdata = swapped; // RL1
                end
            end
            OP_DIRLD: begin
                next_st.done = 1'b1; // RL5
            end
            OP_DIRLD_BAD: begin
                next_st.bad_sel = 1'b1;
                next_st.done    = 1'b1;
            end
            OP_NONE: begin
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st.w_we      <= 1'b0;
            st.w_wdata   <= '0;
            st.f_we      <= 1'b0;
            st.f_waddr   <= '0;
            st.f_wdata   <= '0;
            st.flags_we  <= 1'b0;
            st.done      <= 1'b0;
            st.bad_sel   <= 1'b0;
            st.file_addr <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // direction bank
    // ************************************************************
    // ordinary file accesses go straight to the bank, where both write paths meet
    assign bank_bus.fa_valid = fa_valid; // RL4
    assign bank_bus.fa_we    = fa_we; // RL4
    assign bank_bus.fa_addr  = fa_addr;
    assign bank_bus.fa_wdata = fa_wdata;

    dir_bank u_dir_bank (
        .mclk (mclk),
        .rstn (rstn),
        .bus  (bank_bus.bank)
    );

    // ************************************************************
    // instruction results
    // ************************************************************
    assign w_we        = st.w_we;
    assign w_wdata     = st.w_wdata;
    assign f_we        = st.f_we;
    assign f_waddr     = st.f_waddr;
    assign f_wdata     = st.f_wdata;
    // registered address only echoes the last decode; file_value is sampled live
    assign file_addr   = st.file_addr;
    assign flags_we    = st.flags_we; // RL5
    assign exec_done   = st.done;
    assign bad_dir_sel = st.bad_sel;

    // ************************************************************
    // file-access answers
    // ************************************************************
    // all three come from the bank's own flops, one cycle after the access
    assign fa_rdata    = bank_bus.fa_rdata;
    assign fa_rvalid   = bank_bus.fa_rvalid;
    assign fa_hit      = bank_bus.fa_hit;

    // ************************************************************
    // direction registers
    // ************************************************************
    assign dir_a       = bank_bus.dir_q[0];
    assign dir_b       = bank_bus.dir_q[1];
    assign dir_c       = bank_bus.dir_q[2];

endmodule : nibdir_core

/* nibdir_properties.sv */
// assertions on the ports of the decoder core
module nibdir_props
    import nibdir_pkg::*;
(
    input wire logic               mclk,
    input wire logic               rstn,
    input wire logic               instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    input wire byte_t              w_value,
    input wire byte_t              file_value,
    input wire logic               fa_valid,
    input wire logic               fa_we,
    input wire logic [7:0]         fa_addr,
    input wire byte_t              fa_wdata,
    input wire logic               w_we,
    input wire byte_t              w_wdata,
    input wire logic               f_we,
    input wire logic [6:0]         f_waddr,
    input wire byte_t              f_wdata,
    input wire logic               flags_we,
    input wire logic               exec_done,
    input wire logic               bad_dir_sel,
    input wire byte_t              dir_a
);
    // ****************
    // decode helpers
    // ****************
    logic       nib;
    logic       dld;
    logic [6:0] fad;
    byte_t      swp;
    assign nib = instr_valid && instr[13:8] == NIBX_OPCODE;
    assign dld = instr_valid && instr[13:4] == DIRLD_OPCODE && !instr[3];
    assign fad = instr[6:0];
    assign swp = {file_value[3:0], file_value[7:4]};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ****************
    // properties
    // ****************
    AST_NIBX_ACC: assert property (
        nib && !instr[7] |=> w_we && !f_we && w_wdata == $past(swp))
        else $error("bad accumulator result");
    AST_NIBX_FILE: assert property (
        nib && instr[7] |=> f_we && !w_we && f_wdata == $past(swp) && f_waddr == $past(fad))
        else $error("bad file write-back");
    AST_DIRLD: assert property (
        dld && instr[2:0] == DIR_SEL_FIRST |=> dir_a == $past(w_value) && exec_done)
        else $error("direction load not taken");
    AST_BAD_SEL: assert property (
        dld && instr[2:0] < DIR_SEL_FIRST |=> bad_dir_sel && exec_done && !w_we && !f_we)
        else $error("bad selector not flagged");
    AST_BAD_KEEP: assert property (
        dld && instr[2:0] < DIR_SEL_FIRST && !fa_valid |=> $stable(dir_a))
        else $error("bad selector changed a direction register");
    AST_FILE_PATH: assert property (
        !instr_valid && fa_valid && fa_we && fa_addr == DIR_FILE_BASE |=> dir_a == $past(fa_wdata))
        else $error("file write to direction reg lost");
    AST_NO_FLAGS: assert property (flags_we == 1'b0)
        else $error("status flags written");
    AST_IDLE: assert property (
        !instr_valid |=> !exec_done && !w_we && !f_we && !bad_dir_sel)
        else $error("activity without instruction");
endmodule : nibdir_props

/* nibdir_core_bench.sv */
// self-checking bench for the decoder core
module nibdir_core_bench
    import nibdir_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rstn = 0, iv = 0, fv = 0, fw = 0, w_we, f_we, flw, done, bad, rv, hit;
    logic [13:0] ins = '0;
    logic [7:0] fad = '0;
    logic [6:0] fa7, wa;
    byte_t wv = '0, fval = '0, fwd = '0, wd, fd, rd, da, db, dc;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    nibdir_core u_dut (.mclk(mclk), .rstn(rstn), .instr_valid(iv), .instr(ins), .w_value(wv),
        .file_value(fval), .fa_valid(fv), .fa_we(fw), .fa_addr(fad), .fa_wdata(fwd),
        .file_addr(fa7), .w_we(w_we), .w_wdata(wd), .f_we(f_we), .f_waddr(wa), .f_wdata(fd),
        .flags_we(flw), .exec_done(done), .bad_dir_sel(bad), .fa_rdata(rd), .fa_rvalid(rv),
        .fa_hit(hit), .dir_a(da), .dir_b(db), .dir_c(dc));
    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run_i(input logic [13:0] w, input byte_t acc, input byte_t f);
        @(posedge mclk);
        iv <= 1'b1;
        ins <= w;
        wv <= acc;
        fval <= f;
        @(posedge mclk);
        iv <= 1'b0;
        #1;
    endtask : run_i
    task automatic run_f(input logic we, input logic [7:0] a, input byte_t d);
        @(posedge mclk);
        fv <= 1'b1;
        fw <= we;
        fad <= a;
        fwd <= d;
        @(posedge mclk);
        fv <= 1'b0;
        #1;
    endtask : run_f
    function automatic byte_t dir_of(input int s);
        return s == 5 ? da : s == 6 ? db : dc;
    endfunction : dir_of
    // ****************
    // scenarios
    // ****************
    task automatic t_dirld;
        for (int s = 0; s < 8; s++) begin
            run_i(14'h0060 | 14'(s), 8'h30 + 8'(s), 8'h00);
            check({7'h0, done}, 8'h01);
            check({7'h0, bad}, {7'h0, s < 5});
            check(s < 5 ? da : dir_of(s), s < 5 ? 8'hff : 8'h30 + 8'(s));
        end
        // bit 3 set is not a direction load
        run_i(14'h006d, 8'h77, 8'h00);
        check({7'h0, done}, 8'h00);
        check(da, 8'h35);
        $display("direction load test done");
    endtask : t_dirld
    task automatic t_file;
        run_f(1'b1, 8'h86, 8'h9c);
        check(db, 8'h9c);
        run_f(1'b0, 8'h87, 8'h00);
        check({6'h0, rv, hit}, 8'h03);
        check(rd, 8'h37);
        run_f(1'b1, 8'h88, 8'h11);
        run_f(1'b0, 8'h88, 8'h00);
        check({6'h0, rv, hit}, 8'h02);
        check(rd, 8'h00);
        check(dc, 8'h37);
        run_f(1'b1, 8'h85, 8'h5a);
        check(da, 8'h5a);
        run_f(1'b0, 8'h85, 8'h00);
        check(rd, 8'h5a);
        $display("file access test done");
    endtask : t_file
    task automatic t_nibx;
        byte_t v[3] = '{8'ha5, 8'h0f, 8'hc3};
        foreach (v[i]) begin
            run_i(14'h0e05, 8'h00, v[i]);
            check({6'h0, w_we, f_we}, 8'h02);
            check(wd, {v[i][3:0], v[i][7:4]});
            check({1'b0, fa7}, 8'h05);
            run_i(14'h0eff, 8'h00, v[i]);
            check({5'h0, w_we, f_we, done}, 8'h03);
            check({1'b0, wa}, 8'h7f);
            check({1'b0, fa7}, 8'h7f);
            check(fd, {v[i][3:0], v[i][7:4]});
            check({7'h0, flw}, 8'h00);
        end
        $display("nibble exchange test done");
    endtask : t_nibx
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        check(da & db & dc, 8'hff);
        t_dirld();
        t_file();
        t_nibx();
        summarize();
    end
endmodule : nibdir_core_bench
bind nibdir_core nibdir_props u_props (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid),
    .instr(instr), .w_value(w_value), .file_value(file_value), .fa_valid(fa_valid),
    .fa_we(fa_we), .fa_addr(fa_addr), .fa_wdata(fa_wdata), .w_we(w_we), .w_wdata(w_wdata),
    .f_we(f_we), .f_waddr(f_waddr), .f_wdata(f_wdata), .flags_we(flags_we),
    .exec_done(exec_done), .bad_dir_sel(bad_dir_sel), .dir_a(dir_a));
